// *** src/tile_resource_control.sv ***
`default_nettype none
// Notes on behaviour
// R1 - Fixed counts of timers, chanends, clock blocks, etc.
// R2 - After-time condition gates timer ready.
// R3 - Mode 2 value picks event or interrupt.
// R4 - Syncs, threads, locks ignore config ops.
// R5 - Mode 0 switches clock block on/off.
// R6 - Run start; running block refuses config.
// R7 - Fall delay postpones falling edge.
// R8 - Rise delay postpones rising edge.
// R9 - Delayed edge never passes next opposite edge.
// R10 - Two software memory miss resources.
// R11 - Enabled swmem routes and signals misses.
// R12 - Software reports miss serviced with run.
// R13 - Operand mode, long select, value decode.
// R14 - Undefined mode leaves resource unchanged.
module tile_resource_control #(
  parameter int NUM_TIMERS = tile_res_pkg::NUM_TIMERS,
  parameter int NUM_CHANENDS = tile_res_pkg::NUM_CHANENDS,
  parameter int NUM_CLKBLKS = tile_res_pkg::NUM_CLKBLKS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Configuration operation from the core
  input wire logic cfg_valid,
  input wire logic data_valid,
  input wire logic [2:0] cfg_type,
  input wire logic [4:0] cfg_index,
  input wire logic [15:0] cfg_operand,
  input wire logic [31:0] cfg_data,
  // Time base and per-resource raw triggers
  input wire logic [31:0] time_now,
  input wire logic [NUM_CHANENDS-1:0] chan_trig,
  input wire logic [NUM_CLKBLKS-1:0] clk_in,
  input wire logic [1:0] swmem_miss,
  // Status out
  output logic cfg_refused,
  output logic [NUM_TIMERS-1:0] timer_ready,
  output logic [NUM_TIMERS-1:0] timer_event,
  output logic [NUM_TIMERS-1:0] timer_irq,
  output logic [NUM_CHANENDS-1:0] chan_event,
  output logic [NUM_CHANENDS-1:0] chan_irq,
  output logic [NUM_CLKBLKS-1:0] clkblk_on,
  output logic [NUM_CLKBLKS-1:0] clkblk_running,
  output logic [NUM_CLKBLKS-1:0] clk_out,
  output logic [1:0] swmem_route,
  output logic [1:0] swmem_pending,
  output logic [1:0] swmem_event,
  output logic [1:0] swmem_irq
);
  // Operand decode
  logic [2:0] op_mode;
  logic [3:0] op_long;
  logic [8:0] op_val;
  logic is_long;
  assign op_mode = cfg_operand[tile_res_pkg::MODE_MSB:tile_res_pkg::MODE_LSB]; // [R13]
  assign op_long = cfg_operand[tile_res_pkg::LONG_MSB:tile_res_pkg::LONG_LSB]; // [R13]
  assign op_val = cfg_operand[tile_res_pkg::VAL_MSB:tile_res_pkg::VAL_LSB]; // [R13]
  assign is_long = (op_mode == tile_res_pkg::MODE_LONG); // [R13]

  // Short mode: mode field, long mode: selector must match too
  function automatic logic hit_short(input logic [2:0] m, input logic [2:0] want);
    hit_short = (m == want) && (m != tile_res_pkg::MODE_LONG); // [R14]
  endfunction

  logic long_run;
  assign long_run = is_long && (op_long == tile_res_pkg::LONG_RUN);

  // Refusal flag: clock block running, or op on an unconfigurable type
  logic refuse_now;
  always_comb begin
    refuse_now = 1'b0;
    if (cfg_valid) begin
      case (cfg_type)
        tile_res_pkg::TYPE_SYNC, tile_res_pkg::TYPE_THREAD,
        tile_res_pkg::TYPE_LOCK: refuse_now = 1'b1; // [R4]
        tile_res_pkg::TYPE_CLKBLK: begin
          if (cfg_index < 5'(NUM_CLKBLKS)) begin
            refuse_now = clkblk_running[cfg_index[2:0]]; // [R6]
          end
        end
        default: refuse_now = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg_refused <= 1'b0;
    end else begin
      cfg_refused <= refuse_now;
    end
  end

  // Timers: condition, compare value and event/interrupt choice
  logic [NUM_TIMERS-1:0] t_cond_reg;
  logic [NUM_TIMERS-1:0] t_int_reg;
  logic [31:0] t_time_reg [NUM_TIMERS];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer // [R1]
      logic sel;
      logic rdy;
      assign sel = (cfg_type == tile_res_pkg::TYPE_TIMER) && (cfg_index == 5'(gi));
      // Signed difference keeps the compare correct across wrap
      assign rdy = !t_cond_reg[gi] || ($signed(time_now - t_time_reg[gi]) > 0); // [R2]
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          t_cond_reg[gi] <= 1'b0;
          t_int_reg[gi] <= 1'b0; // [R3]
          t_time_reg[gi] <= tile_res_pkg::TIME_RESET;
        end else begin
          if (cfg_valid && sel && hit_short(op_mode, tile_res_pkg::MODE_COND)) begin
            t_cond_reg[gi] <= (op_val == tile_res_pkg::VAL_READY_AFTER_TIME_CONDITION); // [R2]
          end
          if (cfg_valid && sel && hit_short(op_mode, tile_res_pkg::MODE_IE)) begin
            t_int_reg[gi] <= (op_val == tile_res_pkg::VAL_SIG_INT); // [R3]
          end
          if (data_valid && sel) begin
            t_time_reg[gi] <= cfg_data; // [R2]
          end
        end
      end
      // Ready routed as event or interrupt
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          timer_ready[gi] <= 1'b0;
          timer_event[gi] <= 1'b0;
          timer_irq[gi] <= 1'b0;
        end else begin
          timer_ready[gi] <= rdy; // [R2]
          timer_event[gi] <= rdy && !t_int_reg[gi]; // [R3]
          timer_irq[gi] <= rdy && t_int_reg[gi]; // [R3]
        end
      end
    end
  endgenerate

  // Channel ends: only the event/interrupt choice is configurable
  logic [NUM_CHANENDS-1:0] c_int_reg;
  generate
    for (gi = 0; gi < NUM_CHANENDS; gi++) begin : g_chan // [R1]
      logic sel;
      assign sel = (cfg_type == tile_res_pkg::TYPE_CHANEND) && (cfg_index == 5'(gi));
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          c_int_reg[gi] <= 1'b0;
          chan_event[gi] <= 1'b0;
          chan_irq[gi] <= 1'b0;
        end else begin
          if (cfg_valid && sel && hit_short(op_mode, tile_res_pkg::MODE_IE)) begin
            c_int_reg[gi] <= (op_val == tile_res_pkg::VAL_SIG_INT); // [R3]
          end
          chan_event[gi] <= chan_trig[gi] && !c_int_reg[gi]; // [R3]
          chan_irq[gi] <= chan_trig[gi] && c_int_reg[gi]; // [R3]
        end
      end
    end
  endgenerate

  // Clock blocks: on/off, run, edge delays and delayed output
  generate
    for (gi = 0; gi < NUM_CLKBLKS; gi++) begin : g_clk // [R1]
      logic sel;
      logic ok;
      logic [8:0] fall_dly_reg;
      logic [8:0] rise_dly_reg;
      logic in_prev_reg;
      logic [8:0] cnt_reg;
      logic pend_reg;
      assign sel = (cfg_type == tile_res_pkg::TYPE_CLKBLK) && (cfg_index == 5'(gi));
      assign ok = cfg_valid && sel && !clkblk_running[gi]; // [R6]
      // Configuration
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          clkblk_on[gi] <= 1'b0;
          clkblk_running[gi] <= 1'b0;
          fall_dly_reg <= tile_res_pkg::DELAY_RESET;
          rise_dly_reg <= tile_res_pkg::DELAY_RESET;
        end else begin
          if (ok && hit_short(op_mode, tile_res_pkg::MODE_INUSE)) begin
            clkblk_on[gi] <= (op_val == tile_res_pkg::VAL_ON); // [R5]
          end
          // Only a switched-on block may start
          if (ok && long_run && op_val == tile_res_pkg::VAL_RUN_START && clkblk_on[gi]) begin
            clkblk_running[gi] <= 1'b1; // [R6] [R5]
          end
          if (ok && is_long && op_long == tile_res_pkg::LONG_FALL_DELAY) begin
            fall_dly_reg <= op_val; // [R7]
          end
          if (ok && is_long && op_long == tile_res_pkg::LONG_RISE_DELAY) begin
            rise_dly_reg <= op_val; // [R8]
          end
        end
      end
      // Edge delay: a new input edge cuts any pending one short
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          in_prev_reg <= 1'b0;
          cnt_reg <= 9'h000;
          pend_reg <= 1'b0;
          clk_out[gi] <= 1'b0;
        end else begin
          in_prev_reg <= clk_in[gi];
          if (!clkblk_running[gi]) begin
            pend_reg <= 1'b0;
            clk_out[gi] <= 1'b0;
          end else if (clk_in[gi] != in_prev_reg) begin
            // Opposite edge forces the pending one out first
            if (pend_reg) begin
              clk_out[gi] <= in_prev_reg; // [R9]
            end
            cnt_reg <= clk_in[gi] ? rise_dly_reg : fall_dly_reg; // [R7] [R8]
            pend_reg <= 1'b1;
          end else if (pend_reg) begin
            if (cnt_reg == 9'h000) begin
              clk_out[gi] <= in_prev_reg;
              pend_reg <= 1'b0;
            end else begin
              cnt_reg <= cnt_reg - 9'h001; // [R7] [R8]
            end
          end
        end
      end
    end
  endgenerate

  // Software memory miss resources: 0 read, 1 write
  logic [1:0] s_int_reg;
  generate
    for (gi = 0; gi < tile_res_pkg::NUM_SWMEM; gi++) begin : g_swmem // [R10]
      logic sel;
      assign sel = cfg_valid && (cfg_type == tile_res_pkg::TYPE_SWMEM) && (cfg_index == 5'(gi));
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          swmem_route[gi] <= 1'b0;
          s_int_reg[gi] <= 1'b0;
          swmem_pending[gi] <= 1'b0;
          swmem_event[gi] <= 1'b0;
          swmem_irq[gi] <= 1'b0;
        end else begin
          if (sel && hit_short(op_mode, tile_res_pkg::MODE_INUSE)) begin
            swmem_route[gi] <= (op_val == tile_res_pkg::VAL_ON); // [R11]
          end
          if (sel && hit_short(op_mode, tile_res_pkg::MODE_IE)) begin
            s_int_reg[gi] <= (op_val == tile_res_pkg::VAL_SIG_INT); // [R3]
          end
          // A new miss wins over a same-cycle serviced report
          if (swmem_route[gi] && swmem_miss[gi]) begin
            swmem_pending[gi] <= 1'b1; // [R11]
          end else if (sel && long_run && op_val == tile_res_pkg::VAL_SERVICED) begin
            swmem_pending[gi] <= 1'b0; // [R12]
          end
          swmem_event[gi] <= swmem_route[gi] && swmem_miss[gi] && !s_int_reg[gi]; // [R11]
          swmem_irq[gi] <= swmem_route[gi] && swmem_miss[gi] && s_int_reg[gi]; // [R11]
        end
      end
    end
  endgenerate

  // Checks
  a_refuse_running: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg_valid && cfg_type == tile_res_pkg::TYPE_CLKBLK && cfg_index == 5'h5 &&
    clkblk_running[5] |=> cfg_refused && clkblk_running[5]) // [R6]
    else $error("running clock block not refused");
  a_run_sticks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkblk_running[5] |=> clkblk_running[5] && $stable(g_clk[5].rise_dly_reg)) // [R6]
    else $error("running clock block changed");
  a_cfg_locked_types: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cfg_valid && cfg_type == tile_res_pkg::TYPE_LOCK |=> cfg_refused) // [R4]
    else $error("lock config not refused");
  a_timer_cond: assert property (@(posedge clk_sys) disable iff (!reset_n)
    t_cond_reg[3] && $signed(time_now - t_time_reg[3]) <= 0 |=> !timer_ready[3]) // [R2]
    else $error("timer ready before compare time");
  a_timer_nocond: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reset_n && !t_cond_reg[0] |=> timer_ready[0]) // [R2]
    else $error("timer not ready without condition");
  a_ie_exclusive: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !(timer_event[0] && timer_irq[0]) && !(chan_event[0] && chan_irq[0])) // [R3]
    else $error("event and interrupt together");
  a_chan_event: assert property (@(posedge clk_sys) disable iff (!reset_n)
    chan_trig[0] && !c_int_reg[0] |=> chan_event[0]) // [R3]
    else $error("chanend event missing");
  a_swmem_miss: assert property (@(posedge clk_sys) disable iff (!reset_n)
    swmem_route[0] && swmem_miss[0] |=> swmem_pending[0] && (swmem_event[0] || swmem_irq[0])) // [R11]
    else $error("swmem miss not signalled");
  a_swmem_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !swmem_route[1] |=> !swmem_event[1] && !swmem_irq[1]) // [R11]
    else $error("swmem signalled while off");
  a_clk_zero_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkblk_running[0] && g_clk[0].rise_dly_reg == 9'h000 && $rose(clk_in[0]) &&
    !g_clk[0].pend_reg ##1 clk_in[0] |=> clk_out[0]) // [R8]
    else $error("rise edge not passed with zero delay");
  c_timer_irq: cover property (@(posedge clk_sys) timer_irq[0]);
  c_clk_run: cover property (@(posedge clk_sys) $rose(clkblk_running[0]));
  c_swmem_serviced: cover property (@(posedge clk_sys) $fell(swmem_pending[0]));
  c_refused: cover property (@(posedge clk_sys) cfg_refused);
endmodule
`default_nettype wire

// *** inc/tile_res_pkg.sv ***
`default_nettype none
package tile_res_pkg;
  // Resource counts per tile
  localparam int NUM_TIMERS = 10;
  localparam int NUM_CHANENDS = 32;
  localparam int NUM_CLKBLKS = 6;
  localparam int NUM_SYNCS = 7;
  localparam int NUM_THREADS = 8;
  localparam int NUM_LOCKS = 4;
  localparam int NUM_SWMEM = 2;
  // Resource type codes on the request port
  localparam logic [2:0] TYPE_TIMER = 3'h0;
  localparam logic [2:0] TYPE_CHANEND = 3'h1;
  localparam logic [2:0] TYPE_CLKBLK = 3'h2;
  localparam logic [2:0] TYPE_SYNC = 3'h3;
  localparam logic [2:0] TYPE_THREAD = 3'h4;
  localparam logic [2:0] TYPE_LOCK = 3'h5;
  localparam logic [2:0] TYPE_SWMEM = 3'h6;
  // Operand field layout
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int VAL_LSB = 3;
  localparam int VAL_MSB = 11;
  localparam int LONG_LSB = 12;
  localparam int LONG_MSB = 15;
  localparam logic [2:0] MODE_LONG = 3'h7;
  // Short mode codes
  localparam logic [2:0] MODE_INUSE = 3'h0;
  localparam logic [2:0] MODE_COND = 3'h1;
  localparam logic [2:0] MODE_IE = 3'h2;
  localparam logic [2:0] MODE_RUN = 3'h7;
  // Long setting selectors
  localparam logic [3:0] LONG_RUN = 4'h0;
  localparam logic [3:0] LONG_FALL_DELAY = 4'h8;
  localparam logic [3:0] LONG_RISE_DELAY = 4'h9;
  // Values
  localparam logic [8:0] VAL_ON = 9'h001;
  localparam logic [8:0] VAL_OFF = 9'h000;
  localparam logic [8:0] VAL_RUN_START = 9'h001;
  localparam logic [8:0] VAL_RUN_HALT = 9'h000;
  localparam logic [8:0] VAL_SERVICED = 9'h001;
  localparam logic [8:0] VAL_SIG_INT = 9'h001;
  localparam logic [8:0] VAL_READY_AFTER_TIME_CONDITION = 9'h001;
  // Reset values
  localparam logic [8:0] DELAY_RESET = 9'h000;
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// *** verif/core_model.sv ***
`default_nettype none
module core_model (
  // Clock
  input wire logic clk_sys,
  // Operation to the block
  output logic cfg_valid,
  output logic data_valid,
  output logic [2:0] cfg_type,
  output logic [4:0] cfg_index,
  output logic [15:0] cfg_operand,
  output logic [31:0] cfg_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle at time zero
  initial begin
    cfg_valid = 1'b0;
    data_valid = 1'b0;
    cfg_type = 3'h0;
    cfg_index = 5'h00;
    cfg_operand = 16'h0000;
    cfg_data = 32'h0000_0000;
  end
  // One-cycle config pulse; released operand is scrambled so no stale value lingers
  task automatic op(input logic [2:0] t, input logic [4:0] i, input logic [15:0] o);
    @(posedge clk_sys);
    cfg_valid <= 1'b1;
    cfg_type <= t;
    cfg_index <= i;
    cfg_operand <= o;
    @(posedge clk_sys);
    cfg_valid <= 1'b0;
    cfg_operand <= ~o;
  endtask
  // Compare value load for one timer
  task automatic load(input logic [4:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    data_valid <= 1'b1;
    cfg_type <= tile_res_pkg::TYPE_TIMER;
    cfg_index <= i;
    cfg_data <= d;
    @(posedge clk_sys);
    data_valid <= 1'b0;
    cfg_data <= ~d;
  endtask
  // Miss handled: long run setting with value one
  task automatic serviced(input logic [4:0] i);
    op(tile_res_pkg::TYPE_SWMEM, i, 16'h000F);
  endtask
  // Software switches a block on before any use
  task automatic switch_on(input logic [2:0] t, input logic [4:0] i);
    op(t, i, 16'h0008);
  endtask
endmodule
`default_nettype wire

// *** verif/tb_tile_resource_control.sv ***
`default_nettype none
module tb_tile_resource_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, cfg_valid, data_valid, cfg_refused;
  logic [2:0] cfg_type;
  logic [4:0] cfg_index;
  logic [15:0] cfg_operand;
  logic [31:0] cfg_data, time_now, chan_trig, chan_event, chan_irq;
  logic [5:0] clk_in, clkblk_on, clkblk_running, clk_out;
  logic [9:0] timer_ready, timer_event, timer_irq;
  logic [1:0] swmem_miss, swmem_route, swmem_pending, swmem_event, swmem_irq, irq_seen, ev_seen;
  int fails, check_count, seen;
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Free running time base, zeroed while in reset
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      time_now <= 32'h0000_0000;
    end else begin
      time_now <= time_now + 32'h0000_0001;
    end
  end
  core_model core (.clk_sys(clk_sys), .cfg_valid(cfg_valid), .data_valid(data_valid),
    .cfg_type(cfg_type), .cfg_index(cfg_index), .cfg_operand(cfg_operand), .cfg_data(cfg_data));
  tile_resource_control uut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg_valid(cfg_valid),
    .data_valid(data_valid), .cfg_type(cfg_type), .cfg_index(cfg_index),
    .cfg_operand(cfg_operand), .cfg_data(cfg_data), .time_now(time_now),
    .chan_trig(chan_trig), .clk_in(clk_in), .swmem_miss(swmem_miss),
    .cfg_refused(cfg_refused), .timer_ready(timer_ready), .timer_event(timer_event),
    .timer_irq(timer_irq), .chan_event(chan_event), .chan_irq(chan_irq),
    .clkblk_on(clkblk_on), .clkblk_running(clkblk_running), .clk_out(clk_out),
    .swmem_route(swmem_route), .swmem_pending(swmem_pending), .swmem_event(swmem_event),
    .swmem_irq(swmem_irq));
  // Operand builders: value sits above the three mode bits
  function automatic logic [15:0] s_op(input logic [2:0] m, input logic [8:0] v);
    return {4'h0, v, m};
  endfunction
  function automatic logic [15:0] l_op(input logic [3:0] s, input logic [8:0] v);
    return {s, v, 3'h7};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Refusal is a one-cycle pulse, so count pulses over a short window
  task automatic expect_refuse(input int n, input string msg);
    int c;
    c = 0;
    #1;
    repeat (3) begin
      if (cfg_refused === 1'b1) c++;
      @(posedge clk_sys);
      #1;
    end
    chk(c, n, msg);
  endtask
  // Input edge on block 5, output must follow exactly d + 2 core cycles after it is driven
  task automatic clk_edge(input logic v, input int d);
    @(posedge clk_sys);
    clk_in[5] <= v;
    settle(d + 1);
    chk(clk_out[5], !v, "edge too early");
    settle(1);
    chk(clk_out[5], v, "edge too late");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well above the hundred or so cycles the tests need
  initial begin
    #(40 * 5000);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    reset_n = 1'b0;
    chan_trig = 32'h0000_0000;
    clk_in = 6'h00;
    swmem_miss = 2'h0;
    fails = 0;
    check_count = 0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    settle(2);
    chk(timer_event, 32'h0000_03ff, "timers default to events");
    chk(timer_irq, 0, "no timer irq at reset");
    chk(clkblk_on, 0, "clock blocks off at reset");
    $display("test reset done");
    core.op(tile_res_pkg::TYPE_TIMER, 5'd3, s_op(3'h1, 9'h001));
    core.load(5'd3, time_now + 32'h0000_0014);
    settle(3);
    chk(timer_ready[3], 0, "timer ready too soon");
    settle(20);
    chk(timer_ready[3], 1, "timer not ready after compare");
    core.op(tile_res_pkg::TYPE_TIMER, 5'd9, s_op(3'h2, 9'h001));
    core.op(tile_res_pkg::TYPE_TIMER, 5'd9, s_op(3'h3, 9'h000));
    settle(2);
    chk(timer_irq[9], 1, "timer irq mode");
    chk(timer_event[9], 0, "timer event off in irq mode");
    $display("test timer done");
    @(posedge clk_sys);
    chan_trig <= 32'h8000_0001;
    core.op(tile_res_pkg::TYPE_CHANEND, 5'd31, s_op(3'h2, 9'h001));
    core.op(tile_res_pkg::TYPE_CHANEND, 5'd0, s_op(3'h5, 9'h001));
    settle(2);
    chk(chan_irq, 32'h8000_0000, "chanend irq routing");
    chk(chan_event, 32'h0000_0001, "chanend event routing");
    $display("test chanend done");
    for (int t = 3; t <= 5; t++) begin
      core.op(3'(t), 5'd0, s_op(3'h0, 9'h001));
      expect_refuse(1, "sync thread lock op taken");
    end
    $display("test unconfigurable done");
    core.switch_on(tile_res_pkg::TYPE_CLKBLK, 5'd1);
    core.op(tile_res_pkg::TYPE_CLKBLK, 5'd1, s_op(3'h0, 9'h000));
    core.op(tile_res_pkg::TYPE_CLKBLK, 5'd0, l_op(4'h0, 9'h001));
    core.switch_on(tile_res_pkg::TYPE_CLKBLK, 5'd5);
    core.op(tile_res_pkg::TYPE_CLKBLK, 5'd5, l_op(4'h8, 9'h003));
    core.op(tile_res_pkg::TYPE_CLKBLK, 5'd5, l_op(4'h9, 9'h002));
    core.op(tile_res_pkg::TYPE_CLKBLK, 5'd5, l_op(4'h0, 9'h001));
    settle(2);
    chk(clkblk_on, 32'h0000_0020, "clock block on and off");
    chk(clkblk_running, 32'h0000_0020, "clock block running");
    clk_edge(1'b1, 2);
    clk_edge(1'b0, 3);
    clk_edge(1'b1, 2);
    @(posedge clk_sys);
    clk_in[5] <= 1'b0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    clk_in[5] <= 1'b1;
    seen = 0;
    repeat (3) begin
      #1;
      if (clk_out[5] === 1'b0) seen++;
      @(posedge clk_sys);
    end
    chk(seen > 0, 1, "fall delayed past rising input");
    core.op(tile_res_pkg::TYPE_CLKBLK, 5'd5, s_op(3'h0, 9'h000));
    expect_refuse(1, "running block not refused");
    chk(clkblk_on[5], 1, "running block reconfigured");
    // Block 0 keeps its reset delays, so a rise passes two cycles after it is driven
    core.switch_on(tile_res_pkg::TYPE_CLKBLK, 5'd0);
    core.op(tile_res_pkg::TYPE_CLKBLK, 5'd0, l_op(4'h0, 9'h001));
    @(posedge clk_sys);
    clk_in[0] <= 1'b1;
    settle(1);
    chk(clk_out[0], 0, "zero delay rise early");
    settle(1);
    chk(clk_out[0], 1, "zero delay rise late");
    $display("test clock block done");
    core.op(tile_res_pkg::TYPE_SWMEM, 5'd0, s_op(3'h2, 9'h001));
    core.switch_on(tile_res_pkg::TYPE_SWMEM, 5'd0);
    core.switch_on(tile_res_pkg::TYPE_SWMEM, 5'd1);
    @(posedge clk_sys);
    swmem_miss <= 2'b11;
    @(posedge clk_sys);
    swmem_miss <= 2'b00;
    irq_seen = 2'b00;
    ev_seen = 2'b00;
    repeat (3) begin
      #1;
      irq_seen |= swmem_irq;
      ev_seen |= swmem_event;
      @(posedge clk_sys);
    end
    #1;
    chk(irq_seen, 2'b01, "swmem irq routing");
    chk(ev_seen, 2'b10, "swmem event routing");
    chk(swmem_route, 2'b11, "swmem routed to cache");
    chk(swmem_pending, 2'b11, "swmem misses pending");
    core.serviced(5'd0);
    settle(2);
    chk(swmem_pending, 2'b10, "serviced miss cleared");
    $display("test swmem done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
